/* hw/supply_limiter_consts.vh */
// constants for the supply voltage limiter control block
`ifndef SUPPLY_LIMITER_CONSTS_VH
`define SUPPLY_LIMITER_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_INFLECTION     8'h0A
`define OFS_RATES_ENABLE   8'h0B
`define OFS_THRESHOLD      8'h0C
`define OFS_ATTN_HOLDOFF   8'h0D
`define OFS_GAIN_LINK      8'h0E
`define OFS_CLIP_LEVEL     8'h0F
`define OFS_FIRST          8'h0A
`define REG_COUNT          6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_INFLECTION     8'h22
`define RST_RATES_ENABLE   8'hA0
`define RST_THRESHOLD      8'h22
`define RST_ATTN_HOLDOFF   8'h65
`define RST_GAIN_LINK      8'h00
`define RST_CLIP_LEVEL     8'hFF

// ----------------------------------------------------------------
// writable bit masks (reserved bits read zero)
// ----------------------------------------------------------------
`define MASK_RATES_ENABLE  8'hF1
`define MASK_GAIN_LINK     8'h0F
`define MASK_FULL          8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RELEASE_HI         7
`define RELEASE_LO         6
`define ATTACK_HI          5
`define ATTACK_LO          4
`define ENABLE_BIT         0
`define ATTN_HI            7
`define ATTN_LO            4
`define HOLD_HI            3
`define HOLD_LO            0
`define LINK_HI            3
`define LINK_LO            0

// ----------------------------------------------------------------
// audio limiter modes
// ----------------------------------------------------------------
`define MODE_OFF           2'h0
`define MODE_ON            2'h1
`define MODE_MUTE_LOW      2'h2
`define MODE_ON_LOW        2'h3

// ----------------------------------------------------------------
// timing: rates and hold-off in cycles of a 40 MHz clock
// ----------------------------------------------------------------
`define CLK_HZ             40000000
`define CYC_PER_MS         (`CLK_HZ / 1000)
`define CYC_PER_US         (`CLK_HZ / 1000000)
`define STEP_DB_X100       75
`define STEP_SCALE         100

`endif

/* hw/limiter_reg_store.v */
// small register store for the limiter control bytes with registered read
`timescale 1ns/1ps
`include "supply_limiter_consts.vh"

module limiter_reg_store
#(
  parameter WIDTH = 8,
  parameter DEPTH = `REG_COUNT,
  parameter AW    = 3
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             wr_en_i,
  input  wire [AW-1:0]    wr_idx_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire [AW-1:0]    rd_idx_i,
  output reg  [WIDTH-1:0] rd_data_o,
  output wire [WIDTH*DEPTH-1:0] all_o
);

  // ----------------------------------------------------------------
  // per-entry storage with reset value and writable mask
  // ----------------------------------------------------------------
  wire [WIDTH*DEPTH-1:0] rst_vals = {`RST_CLIP_LEVEL, `RST_GAIN_LINK, `RST_ATTN_HOLDOFF,
                                     `RST_THRESHOLD, `RST_RATES_ENABLE, `RST_INFLECTION};
  wire [WIDTH*DEPTH-1:0] masks    = {`MASK_FULL, `MASK_GAIN_LINK, `MASK_FULL,
                                     `MASK_FULL, `MASK_RATES_ENABLE, `MASK_FULL};

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : entry
      reg [WIDTH-1:0] val;
      always @(posedge clk_i)
      begin
        if (rst_i)
          val <= rst_vals[g*WIDTH +: WIDTH];
        else if (wr_en_i && wr_idx_i == g)
          val <= wr_data_i & masks[g*WIDTH +: WIDTH];
      end
      assign all_o[g*WIDTH +: WIDTH] = val;
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_o <= {WIDTH{1'b0}};
    else if (rd_idx_i < DEPTH)
      rd_data_o <= all_o[rd_idx_i*WIDTH +: WIDTH];
    else
      rd_data_o <= {WIDTH{1'b0}};
  end

endmodule // limiter_reg_store

/* hw/supply_limiter_control.v */
// supply voltage limiter control registers and gain-reduction engine
// Operation
// - inflection byte resets 0x22, sets knee
// - release codes 3200/1600/1200/800 ms/dB, reset 10
// - attack codes 120/60/30/20 us/dB, reset 10
// - enabled limiter reduces gain at threshold
// - max attenuation 0.75 dB times code+1
// - hold-off 0, 200 ms steps, then longer
// - link bits tie gain to auto inputs
// - registers 0x0A-0x0F reset to listed values
// - volts equal 4 plus 14*code/255
// - mode 11 limits, mode 10 mutes below knee
`timescale 1ns/1ps
`include "supply_limiter_consts.vh"

module supply_limiter_control
#(
  parameter MS_CYCLES = `CYC_PER_MS,
  parameter US_CYCLES = `CYC_PER_US
)
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  output wire [7:0] rdata_o,
  output reg        rvalid_o,
  input  wire [7:0] supply_code_i,
  input  wire [1:0] audio_limiter_mode_i,
  input  wire [7:0] auto_gain_input_one_i,
  input  wire [7:0] auto_gain_input_two_i,
  input  wire [7:0] auto_gain_input_three_i,
  input  wire [7:0] auto_gain_input_four_i,
  output reg  [7:0] attenuation_steps_o,
  output reg        limiter_engaged_o,
  output reg        audio_limiter_active_o,
  output reg        output_mute_o,
  output reg        battery_warn_o,
  output reg  [7:0] linked_gain_o,
  output wire [7:0] battery_knee_level_o,
  output wire [7:0] converter_clip_level_o
);

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  // offsets outside the map are neither stored nor read; reads of them return zero
  wire [7:0] rel_addr = addr_i - `OFS_FIRST;
  wire       in_map   = (addr_i >= `OFS_INFLECTION) && (addr_i <= `OFS_CLIP_LEVEL);
  wire [47:0] regs;

  limiter_reg_store #(.WIDTH(8), .DEPTH(`REG_COUNT), .AW(3)) store
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (wr_i && in_map),
    .wr_idx_i  (rel_addr[2:0]),
    .wr_data_i (wdata_i),
    .rd_idx_i  (in_map ? rel_addr[2:0] : 3'h7),
    .rd_data_o (rdata_o),
    .all_o     (regs)
  );

  // read data comes from a register, so it and this flag stand one cycle after the strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
      rvalid_o <= 1'b0;
    else
      rvalid_o <= rd_i;
  end

  wire [7:0] battery_knee_level = regs[7:0];
  wire [7:0] rates_enable       = regs[15:8];
  wire [7:0] supply_limiter_threshold = regs[23:16];
  wire [7:0] attn_holdoff       = regs[31:24];
  wire [7:0] gain_link          = regs[39:32];
  assign battery_knee_level_o   = battery_knee_level;
  assign converter_clip_level_o = regs[47:40];

  wire [1:0] supply_limiter_release_rate = rates_enable[`RELEASE_HI:`RELEASE_LO];
  wire [1:0] supply_limiter_attack_rate  = rates_enable[`ATTACK_HI:`ATTACK_LO];
  wire       supply_limiter_enable       = rates_enable[`ENABLE_BIT];
  wire [3:0] supply_limiter_max_attenuation = attn_holdoff[`ATTN_HI:`ATTN_LO];
  wire [3:0] supply_limiter_holdoff      = attn_holdoff[`HOLD_HI:`HOLD_LO];
  wire [3:0] gain_link_bits              = gain_link[`LINK_HI:`LINK_LO];

  // ----------------------------------------------------------------
  // rate and hold-off decoding
  // ----------------------------------------------------------------
  // codes compare directly: 4 + 14*code/255 is monotonic, so volts never need computing
  reg [31:0] release_ms;
  reg [31:0] attack_us;
  reg [31:0] hold_ms;

  always @*
  begin
    case (supply_limiter_release_rate)
      2'h0:    release_ms = 32'd3200;
      2'h1:    release_ms = 32'd1600;
      2'h2:    release_ms = 32'd1200;
      default: release_ms = 32'd800;
    endcase
  end

  always @*
  begin
    case (supply_limiter_attack_rate)
      2'h0:    attack_us = 32'd120;
      2'h1:    attack_us = 32'd60;
      2'h2:    attack_us = 32'd30;
      default: attack_us = 32'd20;
    endcase
  end

  // every code is listed so the long codes cannot fall into the 200 ms ramp
  always @*
  begin
    case (supply_limiter_holdoff)
      4'h0:    hold_ms = 32'd0;
      4'h1:    hold_ms = 32'd200;
      4'h2:    hold_ms = 32'd400;
      4'h3:    hold_ms = 32'd600;
      4'h4:    hold_ms = 32'd800;
      4'h5:    hold_ms = 32'd1000;
      4'h6:    hold_ms = 32'd1200;
      4'h7:    hold_ms = 32'd1400;
      4'h8:    hold_ms = 32'd1600;
      4'h9:    hold_ms = 32'd1800;
      4'hA:    hold_ms = 32'd2000;
      4'hB:    hold_ms = 32'd2500;
      4'hC:    hold_ms = 32'd3000;
      4'hD:    hold_ms = 32'd4000;
      4'hE:    hold_ms = 32'd5000;
      4'hF:    hold_ms = 32'd6000;
      default: hold_ms = 32'd0;
    endcase
  end

  // ----------------------------------------------------------------
  // step periods in clock cycles
  // ----------------------------------------------------------------
  // one step is 0.75 dB, so a step period is rate * 0.75; at the full clock rate
  // the release product passes 32 bits, so it is formed in 64 bits and then cut
  wire [63:0] attack_prod      = ({32'h0, attack_us} * US_CYCLES * `STEP_DB_X100) / `STEP_SCALE;
  wire [63:0] release_prod     = ({32'h0, release_ms} * MS_CYCLES * `STEP_DB_X100) / `STEP_SCALE;
  wire [63:0] hold_prod        = {32'h0, hold_ms} * MS_CYCLES;
  wire [31:0] attack_step_cyc  = attack_prod[31:0];
  wire [31:0] release_step_cyc = release_prod[31:0];
  wire [31:0] hold_cyc         = hold_prod[31:0];

  // ----------------------------------------------------------------
  // supply limiter engine
  // ----------------------------------------------------------------
  // one-hot states; any other code falls back to idle
  localparam ST_IDLE    = 3'b001;
  localparam ST_ATTACK  = 3'b010;
  localparam ST_HOLD    = 3'b100;

  reg [2:0]  state;
  reg [31:0] timer;
  wire [4:0] max_steps = {1'b0, supply_limiter_max_attenuation} + 5'h1;
  wire       low_supply = supply_code_i <= supply_limiter_threshold;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      timer <= 32'h0;
      attenuation_steps_o <= 8'h00;
    end
    else if (!supply_limiter_enable)
    begin
      state <= ST_IDLE;
      timer <= 32'h0;
      attenuation_steps_o <= 8'h00;
    end
    else if (attenuation_steps_o > {3'h0, max_steps})
    begin
      // a cap lowered mid-attack is met one step a cycle, so every move but a disable clear stays one step
      attenuation_steps_o <= attenuation_steps_o - 8'h01;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (low_supply)
          begin
            state <= ST_ATTACK;
            timer <= 32'h0;
          end
          else if (attenuation_steps_o != 8'h00)
          begin
            if (timer + 32'h1 >= release_step_cyc)
            begin
              timer <= 32'h0;
              attenuation_steps_o <= attenuation_steps_o - 8'h01;
            end
            else
              timer <= timer + 32'h1;
          end
        end
        ST_ATTACK:
        begin
          if (!low_supply)
          begin
            state <= ST_HOLD;
            timer <= 32'h0;
          end
          else if (timer + 32'h1 >= attack_step_cyc)
          begin
            timer <= 32'h0;
            if (attenuation_steps_o < {3'h0, max_steps})
              attenuation_steps_o <= attenuation_steps_o + 8'h01;
          end
          else
            timer <= timer + 32'h1;
        end
        ST_HOLD:
        begin
          if (low_supply)
          begin
            state <= ST_ATTACK;
            timer <= 32'h0;
          end
          else if (timer >= hold_cyc)
          begin
            state <= ST_IDLE;
            timer <= 32'h0;
          end
          else
            timer <= timer + 32'h1;
        end
        default:
        begin
          state <= ST_IDLE;
          timer <= 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // audio limiter mode, warning and gain link
  // ----------------------------------------------------------------
  wire        below_knee = supply_code_i < battery_knee_level;
  wire [31:0] auto_gain_all = {auto_gain_input_four_i, auto_gain_input_three_i,
                               auto_gain_input_two_i, auto_gain_input_one_i};
  wire [31:0] masked_gain;
  reg  [7:0]  next_linked;
  reg         next_engaged;
  reg         next_active;
  reg         next_mute;
  reg         next_warn;

  // one lane per link bit; an unlinked input adds nothing to the combined gain
  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1)
    begin : link_lane
      assign masked_gain[n*8 +: 8] = gain_link_bits[n] ?
                                     auto_gain_all[n*8 +: 8] : 8'h00;
    end
  endgenerate

  always @*
  begin
    next_linked  = masked_gain[7:0] | masked_gain[15:8] |
                   masked_gain[23:16] | masked_gain[31:24];
    next_engaged = attenuation_steps_o != 8'h00;
    // mode 10 mutes and mode 11 limits only while the supply sits below the knee
    next_active  = (audio_limiter_mode_i == `MODE_ON) ||
                   ((audio_limiter_mode_i == `MODE_ON_LOW) && below_knee);
    next_mute    = (audio_limiter_mode_i == `MODE_MUTE_LOW) && below_knee;
    next_warn    = supply_code_i <= battery_knee_level;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      limiter_engaged_o      <= 1'b0;
      audio_limiter_active_o <= 1'b0;
      output_mute_o          <= 1'b0;
      battery_warn_o         <= 1'b0;
      linked_gain_o          <= 8'h00;
    end
    else
    begin
      limiter_engaged_o      <= next_engaged;
      audio_limiter_active_o <= next_active;
      output_mute_o          <= next_mute;
      battery_warn_o         <= next_warn;
      linked_gain_o          <= next_linked;
    end
  end

endmodule // supply_limiter_control

/* bench/supply_limiter_control_properties.sv */
// concurrent checks on the ports of the supply limiter control block
`timescale 1ns/1ps
module supply_limiter_control_properties
#(
  parameter MS_CYCLES = 40000,
  parameter US_CYCLES = 40
)
(
  input wire       clk_i,
  input wire       rst_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire [7:0] supply_code_i,
  input wire [1:0] audio_limiter_mode_i,
  input wire [7:0] attenuation_steps_o,
  input wire       limiter_engaged_o,
  input wire       audio_limiter_active_o,
  input wire       output_mute_o,
  input wire       battery_warn_o,
  input wire [7:0] battery_knee_level_o,
  input wire [7:0] converter_clip_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // register side
  // ----
  AST_KNEE_WR: assert property (
    wr_i && addr_i == 8'h0A |=> battery_knee_level_o == $past(wdata_i))
    else $error("knee level not taken from write");
  AST_CLIP_WR: assert property (
    wr_i && addr_i == 8'h0F |=> converter_clip_level_o == $past(wdata_i))
    else $error("clip level not taken from write");
  AST_RSVD_RATES: assert property (
    rd_i && addr_i == 8'h0B |=> rdata_o[3:1] == 3'h0)
    else $error("reserved rate bits read nonzero");
  AST_RSVD_LINK: assert property (
    rd_i && addr_i == 8'h0E |=> rdata_o[7:4] == 4'h0)
    else $error("reserved link bits read nonzero");
  // ----
  // limiter side; the previous cycle's inputs decide each registered level
  // ----
  AST_WARN: assert property (
    !$past(rst_i) |-> battery_warn_o == ($past(supply_code_i) <= $past(battery_knee_level_o)))
    else $error("battery warning wrong");
  AST_MUTE: assert property (
    !$past(rst_i) |-> output_mute_o == ($past(audio_limiter_mode_i) == 2'h2
      && $past(supply_code_i) < $past(battery_knee_level_o)))
    else $error("mute level wrong");
  AST_ACTIVE_LOW: assert property (
    !$past(rst_i) && $past(audio_limiter_mode_i) == 2'h3
      |-> audio_limiter_active_o == ($past(supply_code_i) < $past(battery_knee_level_o)))
    else $error("limiter active wrong in knee mode");
  AST_ENGAGED: assert property (
    $stable(attenuation_steps_o) |-> limiter_engaged_o == (attenuation_steps_o != 8'h00))
    else $error("engaged flag disagrees with attenuation");
  AST_ONE_STEP: assert property (
    $changed(attenuation_steps_o) && attenuation_steps_o != 8'h00
      |-> attenuation_steps_o - $past(attenuation_steps_o) == 8'h01
      || $past(attenuation_steps_o) - attenuation_steps_o == 8'h01)
    else $error("attenuation moved by more than one step");
endmodule // supply_limiter_control_properties

bind supply_limiter_control supply_limiter_control_properties
  #(.MS_CYCLES(MS_CYCLES), .US_CYCLES(US_CYCLES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .supply_code_i(supply_code_i),
  .audio_limiter_mode_i(audio_limiter_mode_i), .attenuation_steps_o(attenuation_steps_o),
  .limiter_engaged_o(limiter_engaged_o), .audio_limiter_active_o(audio_limiter_active_o),
  .output_mute_o(output_mute_o), .battery_warn_o(battery_warn_o),
  .battery_knee_level_o(battery_knee_level_o), .converter_clip_level_o(converter_clip_level_o));

/* bench/supply_limiter_control_tb.sv */
// self-checking testbench for the supply limiter control block
`timescale 1ns/1ps
module supply_limiter_control_tb;
  localparam [47:0] RST_TAB = 48'hFF006522A022;
  reg        clk_i, rst_i, wr_i, rd_i;
  reg  [7:0] addr_i, wdata_i, supply_code_i, g1, g2, g3, g4, d, e, s;
  reg  [1:0] audio_limiter_mode_i;
  wire [7:0] rdata_o, attenuation_steps_o, linked_gain_o, knee, clip;
  wire       rvalid_o, engaged, active, mute, warn;
  integer    err_total, compares, i;

  supply_limiter_control #(.MS_CYCLES(4), .US_CYCLES(1)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .supply_code_i(supply_code_i),
    .audio_limiter_mode_i(audio_limiter_mode_i), .auto_gain_input_one_i(g1),
    .auto_gain_input_two_i(g2), .auto_gain_input_three_i(g3), .auto_gain_input_four_i(g4),
    .attenuation_steps_o(attenuation_steps_o), .limiter_engaged_o(engaged),
    .audio_limiter_active_o(active), .output_mute_o(mute), .battery_warn_o(warn),
    .linked_gain_o(linked_gain_o), .battery_knee_level_o(knee), .converter_clip_level_o(clip));

  // reserved bits of the rate and link registers never hold a one
  function [7:0] keep(input [7:0] a, input [7:0] v);
    keep = (a == 8'h0B) ? (v & 8'hF1) : (a == 8'h0E) ? (v & 8'h0F) : v;
  endfunction
  function [7:0] link_exp(input [7:0] m);
    link_exp = (m[0] ? g1 : 8'h00) | (m[1] ? g2 : 8'h00) | (m[2] ? g3 : 8'h00)
      | (m[3] ? g4 : 8'h00);
  endfunction

  task wrap_up;
  begin
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [7:0] ex, input [7:0] got);
  begin
    compares = compares + 1;
    if (got !== ex)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, ex, got);
    end
  end
  endtask
  task settle(input integer n);
  begin
    repeat (n) @(posedge clk_i);
    #1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  // answer comes exactly one cycle after the strobe, so no open wait
  task rd(input [7:0] a, output [7:0] v);
  begin
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid_o});
    v = rdata_o;
  end
  endtask
  task wrchk(input [7:0] a, input [7:0] v);
  begin
    wr(a, v);
    rd(a, d);
    chk("readback", keep(a, v), d);
  end
  endtask
  task wait_steps(input [7:0] ex, input integer lim);
    integer n;
  begin
    n = 0;
    while (attenuation_steps_o !== ex && n < lim)
    begin
      settle(1);
      n = n + 1;
    end
    chk("steps", ex, attenuation_steps_o);
    if (attenuation_steps_o !== ex)
      wrap_up;
  end
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    err_total = 0;
    compares = 0;
    rst_i = 1'b1;
    {wr_i, rd_i, addr_i, wdata_i, g1, g2, g3, g4, audio_limiter_mode_i} = 0;
    supply_code_i = 8'hFF;
    void'($urandom(46));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      rd(8'h0A + i[7:0], d);
      chk("reset", RST_TAB[8*i +: 8], d);
    end
    chk("knee", 8'h22, knee);
    chk("clip", 8'hFF, clip);
    wr(8'h10, 8'h5A);
    rd(8'h10, d);
    chk("unmapped", 8'h00, d);
    $display("test reset done");
    for (i = 0; i < 24; i = i + 1)
    begin
      e = 8'($urandom);
      wrchk(8'h0A + i[7:0] % 8'h06, e);
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      wrchk(8'h0D, {i[3:0], ~i[3:0]});
      wrchk(8'h0B, {i[1:0], i[1:0], 4'hE});
      wrchk(8'h0E, {~i[3:0], i[3:0]});
    end
    $display("test fields done");
    for (i = 0; i < 5; i = i + 1)
    begin
      @(posedge clk_i);
      {g1, g2, g3, g4} <= $urandom;
      e = (i == 4) ? 8'hFF : 8'h01 << i;
      wr(8'h0E, e);
      settle(3);
      chk("link", link_exp(e), linked_gain_o);
    end
    wr(8'h0B, 8'h00);
    wr(8'h0A, 8'h40);
    for (i = 0; i < 12; i = i + 1)
    begin
      @(posedge clk_i);
      audio_limiter_mode_i <= i[1:0];
      s = 8'h3F + i[7:0] / 8'h04;
      supply_code_i <= s;
      settle(3);
      chk("mute", {7'h00, i[1:0] == 2'h2 && s < 8'h40}, {7'h00, mute});
      chk("active", {7'h00, i[1:0] == 2'h1 || (i[1:0] == 2'h3 && s < 8'h40)}, {7'h00, active});
      chk("warn", {7'h00, s <= 8'h40}, {7'h00, warn});
    end
    $display("test modes done");
    @(posedge clk_i);
    audio_limiter_mode_i <= 2'h0;
    supply_code_i <= 8'h81;
    wr(8'h0C, 8'h80);
    wr(8'h0D, 8'h11);
    wr(8'h0B, 8'hF1);
    settle(60);
    chk("above", 8'h00, attenuation_steps_o);
    @(posedge clk_i);
    supply_code_i <= 8'h80;
    wait_steps(8'h02, 200);
    settle(60);
    chk("cap", 8'h02, attenuation_steps_o);
    chk("engaged", 8'h01, {7'h00, engaged});
    // hold 200 ms is 800 cycles, then one 0.75 dB release step at 800 ms/dB is 2400
    @(posedge clk_i);
    supply_code_i <= 8'h81;
    settle(3100);
    chk("hold", 8'h02, attenuation_steps_o);
    wait_steps(8'h01, 200);
    wr(8'h0B, 8'hF0);
    wait_steps(8'h00, 3);
    $display("test engine done");
    wrap_up;
  end
endmodule // supply_limiter_control_tb
